// [design/pma_pkg.sv]
// Package for the PHY management register access block
package pma_pkg;
    localparam logic [11:0] PMA_CMD_OFFSET = 12'h120;
    localparam logic [11:0] PMA_DATA_OFFSET = 12'h124;
    localparam logic [4:0] PMA_PHY_ADDR_RESET = 5'h01;
    localparam logic [4:0] PMA_INDEX_RESET = 5'h00;
    localparam logic [15:0] PMA_DATA_RESET = 16'h0000;
    localparam int PMA_ADDR_MSB = 15;
    localparam int PMA_ADDR_LSB = 11;
    localparam int PMA_INDEX_MSB = 10;
    localparam int PMA_INDEX_LSB = 6;
    localparam int PMA_WNR_BIT = 1;
    localparam int PMA_BUSY_BIT = 0;
    // Management clock: 2.5 MHz max, least half period 200 ns
    localparam int PMA_CLK_HALF_NS = 200;
    localparam int PMA_HCLK_NS = 4;
    localparam int PMA_HALF_CYCLES = (PMA_CLK_HALF_NS + PMA_HCLK_NS - 1) / PMA_HCLK_NS;
    localparam int PMA_FRAME_BITS = 64;
    localparam logic [31:0] PMA_PREAMBLE = 32'hffffffff;
    localparam logic [1:0] PMA_START = 2'h1;
    localparam logic [1:0] PMA_OP_WRITE = 2'h1;
    localparam logic [1:0] PMA_OP_READ = 2'h2;
    localparam logic [1:0] PMA_TA_WRITE = 2'h2;
    localparam logic [1:0] PMA_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        PMA_IDLE = 2'h0,
        PMA_SHIFT = 2'h1,
        PMA_DONE = 2'h2
    } pma_state_t;

    typedef struct packed {
        logic mdc;
        logic mdio_out;
        logic mdio_oe;
    } pma_mdio_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } pma_ahb_req_t;
endpackage

// [design/pma_top.sv]
// PHY management register access: AHB-Lite registers and clause-22 frame engine
`timescale 1ns/1ps
module pma_top
    import pma_pkg::*;
#(
    parameter int HALF_CYCLES = PMA_HALF_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output pma_pkg::pma_mdio_t mdio,
    input wire logic mdio_in
);
    import pma_pkg::*;

    typedef struct packed {
        logic [4:0] phy_addr;
        logic [4:0] phy_register_index;
        logic write_not_read_select;
        logic access_in_progress_flag;
        logic [15:0] data;
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        pma_state_t state;
        logic [15:0] div_cnt;
        logic [6:0] bit_cnt;
        logic [63:0] shreg;
        logic [15:0] rd_shift;
        logic mdc;
        logic mdio_out;
        logic mdio_oe;
        logic [2:0] sync;
        logic in_stable;
    } pma_st_t;

    pma_st_t st_reg;
    pma_st_t st_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic addr_phase;
        logic [31:0] wd;
        logic mdc_rise;
        logic mdc_fall;
        logic [1:0] op;
        logic [1:0] ta;
        st_next = st_reg;
        addr_phase = hsel && hready && htrans == PMA_HTRANS_NONSEQ;
        wd = hwdata;
        mdc_rise = 1'b0;
        mdc_fall = 1'b0;
        op = PMA_OP_READ;
        ta = PMA_TA_WRITE;

        // Pin synchroniser, change accepted when stages two and three agree
        st_next.sync = {st_reg.sync[1:0], mdio_in};
        if (st_reg.sync[2] == st_reg.sync[1]) begin
            st_next.in_stable = st_reg.sync[2];
        end

        // Bus data phase for writes
        if (st_reg.wr_pend) begin
            st_next.wr_pend = 1'b0;
            if (st_reg.wr_addr == PMA_CMD_OFFSET && !st_reg.access_in_progress_flag) begin
                st_next.phy_addr = wd[PMA_ADDR_MSB:PMA_ADDR_LSB];
                st_next.phy_register_index = wd[PMA_INDEX_MSB:PMA_INDEX_LSB];
                st_next.write_not_read_select = wd[PMA_WNR_BIT];
                st_next.access_in_progress_flag = wd[PMA_BUSY_BIT];
            end else if (st_reg.wr_addr == PMA_DATA_OFFSET && !st_reg.access_in_progress_flag) begin
                st_next.data = wd[15:0];
            end
        end

        // Address phase
        if (addr_phase) begin
            st_next.wr_pend = hwrite;
            st_next.wr_addr = haddr[11:0];
            if (haddr[11:0] == PMA_CMD_OFFSET) begin
                st_next.rdata = {16'h0000, st_reg.phy_addr, st_reg.phy_register_index,
                    4'h0, st_reg.write_not_read_select, st_reg.access_in_progress_flag};
            end else if (haddr[11:0] == PMA_DATA_OFFSET) begin
                st_next.rdata = {16'h0000, st_reg.data};
            end else begin
                st_next.rdata = 32'h00000000;
            end
        end

        // Management clock divider
        if (st_reg.state == PMA_SHIFT) begin
            if (st_reg.div_cnt == 16'(HALF_CYCLES - 1)) begin
                st_next.div_cnt = 16'h0000;
                st_next.mdc = !st_reg.mdc;
                mdc_rise = !st_reg.mdc;
                mdc_fall = st_reg.mdc;
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 16'h0001;
            end
        end

        unique case (st_reg.state)
            PMA_IDLE: begin
                if (st_reg.access_in_progress_flag) begin
                    if (st_reg.write_not_read_select) begin
                        op = PMA_OP_WRITE;
                        ta = PMA_TA_WRITE;
                    end else begin
                        op = PMA_OP_READ;
                        ta = 2'h3;
                    end
                    st_next.shreg = {PMA_PREAMBLE, PMA_START, op, st_reg.phy_addr,
                        st_reg.phy_register_index, ta, st_reg.data};
                    st_next.bit_cnt = 7'h00;
                    st_next.div_cnt = 16'h0000;
                    st_next.mdc = 1'b0;
                    st_next.mdio_oe = 1'b1;
                    st_next.mdio_out = PMA_PREAMBLE[31];
                    st_next.state = PMA_SHIFT;
                end
            end
            PMA_SHIFT: begin
                if (mdc_rise && !st_reg.write_not_read_select && st_reg.bit_cnt >= 7'd48) begin
                    st_next.rd_shift = {st_reg.rd_shift[14:0], st_reg.in_stable};
                end
                if (mdc_fall) begin
                    st_next.bit_cnt = st_reg.bit_cnt + 7'h01;
                    st_next.shreg = {st_reg.shreg[62:0], 1'b0};
                    st_next.mdio_out = st_reg.shreg[62];
                    // Read releases the line from the turnaround onward
                    if (!st_reg.write_not_read_select && st_reg.bit_cnt >= 7'd45) begin
                        st_next.mdio_oe = 1'b0;
                    end
                    if (st_reg.bit_cnt == 7'(PMA_FRAME_BITS - 1)) begin
                        st_next.mdio_oe = 1'b0;
                        st_next.mdio_out = 1'b0;
                        st_next.state = PMA_DONE;
                    end
                end
            end
            PMA_DONE: begin
                if (!st_reg.write_not_read_select) begin
                    st_next.data = st_reg.rd_shift;
                end
                st_next.access_in_progress_flag = 1'b0;
                st_next.state = PMA_IDLE;
            end
            default: begin
                st_next.state = PMA_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.phy_addr <= PMA_PHY_ADDR_RESET;
            st_reg.phy_register_index <= PMA_INDEX_RESET;
            st_reg.data <= PMA_DATA_RESET;
            st_reg.state <= PMA_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata = st_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mdio.mdc = st_reg.mdc;
    assign mdio.mdio_out = st_reg.mdio_out;
    assign mdio.mdio_oe = st_reg.mdio_oe;
endmodule

// [testbench/pma_monitor.sv]
// Port checks for the management block
`timescale 1ns/1ps
module pma_monitor
    import pma_pkg::*;
#(
    parameter int HALF_CYCLES = PMA_HALF_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire pma_pkg::pma_mdio_t mdio
);
    // Cycles the management clock has stood high
    logic [15:0] hi_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_cnt <= 16'h0000;
        end else if (mdio.mdc) begin
            hi_cnt <= hi_cnt + 16'h0001;
        end else begin
            hi_cnt <= 16'h0000;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_data_upper_zero: assert property (hsel && !hwrite && haddr[11:0] == 12'h124
        |=> hrdata[31:16] == 16'h0) else $error("data upper half set");
    a_cmd_reserved_zero: assert property (hsel && !hwrite && haddr[11:0] == 12'h120
        |=> hrdata[31:16] == 16'h0 && hrdata[5:2] == 4'h0) else $error("reserved bits set");
    a_mdc_half_period: assert property ($fell(mdio.mdc) |->
        hi_cnt == 16'(HALF_CYCLES)) else $error("clock high time wrong");
    a_frame_start_high: assert property ($rose(mdio.mdio_oe) |->
        mdio.mdio_out && !mdio.mdc) else $error("frame did not open with a one");
    a_idle_when_clear: assert property (hsel && !hwrite && haddr[11:0] == 12'h120
        |=> hrdata[0] || (!mdio.mdc && !mdio.mdio_oe)) else $error("link busy while flag clear");
    a_out_on_low: assert property (mdio.mdio_oe && $changed(mdio.mdio_out) |->
        !mdio.mdc) else $error("data moved while clock high");
endmodule
bind pma_top pma_monitor #(.HALF_CYCLES(HALF_CYCLES)) i_pma_monitor (.hclk, .hresetn, .hsel,
    .haddr, .hwrite, .hrdata, .mdio);

// [testbench/pma_phy_model.sv]
// Behavioural PHY register set behind the management pins
`timescale 1ns/1ps
module pma_phy_model
    import pma_pkg::*;
(
    input pma_pkg::pma_mdio_t mdio,
    output logic mdio_in
);
    logic [15:0] regs [32] = '{default: 16'h0};
    logic [15:0] rd = 16'h0;
    logic [63:0] sh = 64'h0;
    logic drv = 0, dbit = 0;
    int n = 0;
    always @(posedge mdio.mdio_oe) n = 0;
    always @(posedge mdio.mdc) begin
        sh = {sh[62:0], mdio_in};
        n++;
        if (n == 64 && sh[29:23] == 7'h21) regs[sh[22:18]] = sh[15:0];
    end
    always @(negedge mdio.mdc) begin
        if (n == 46 && sh[11:5] == 7'h41) begin
            rd = regs[sh[4:0]];
            drv = 1;
        end
        drv = drv && n < 64;
        dbit = n >= 48 && n < 64 && rd[63 - n];
    end
    // Pull-up holds the released line high
    assign mdio_in = drv ? dbit : !mdio.mdio_oe || mdio.mdio_out;
endmodule

// [testbench/pma_top_tb.sv]
// Self-checking bench for the management register block
`timescale 1ns/1ps
module pma_top_tb;
    import pma_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ph = 0, hreadyout, hresp, mdio_in;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, last, v[4], q[$];
    logic [1:0] htrans = 0;
    logic [4:0] r[4];
    pma_mdio_t mdio;
    int bad_count = 0, checked = 0, seed = 32'hcb2ae849;
    always #2 hclk = ~hclk;
    pma_top #(.HALF_CYCLES(8)) i_pma_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .mdio, .mdio_in);
    pma_phy_model i_pma_phy_model (.mdio, .mdio_in);
    task chk(input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: %h not %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task edge_ready;
        for (int n = 0; n < 9; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        bad_count++;
        report_and_stop;
    endtask
    // A read with c set notes d as its expected data
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c = 0);
        @(posedge hclk);
        if (c) q.push_back(d);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0, a};
        edge_ready;
        {hsel, htrans, hwdata} <= {3'h0, d};
        edge_ready;
        last = hrdata;
    endtask
    always @(posedge hclk) begin
        if (ph && q.size() > 0) chk(hrdata, q.pop_front());
        if (ph) chk({30'h0, hresp, hreadyout}, 32'h1);
        ph = hsel && !hwrite;
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        bus(0, 12'h120, 32'h800, 1);
        bus(0, 12'h124, 32'h0, 1);
        bus(0, 12'h128, 32'h0, 1);
        for (int i = 0; i < 8; i++) begin
            if (i < 4) begin
                r[i] = {2'(i), 3'($random(seed))};
                v[i] = $random(seed);
            end
            bus(1, 12'h124, i < 4 ? v[i] : 32'h0);
            bus(1, 12'h120, {16'h0, 5'h01, r[i % 4], 4'h0, 1'(i < 4), 1'b1});
            bus(1, 12'h124, 32'h5a5a);
            bus(0, 12'h120, {16'h0, 5'h01, r[i % 4], 4'h0, 1'(i < 4), 1'b1}, 1);
            for (int k = 0; k < 1000 && last[0] !== 1'b0; k++) bus(0, 12'h120, 0);
            if (last[0] !== 1'b0) begin
                bad_count++;
                report_and_stop;
            end
            if (i < 4) chk(i_pma_phy_model.regs[r[i]], v[i][15:0]);
            else bus(0, 12'h124, {16'h0, v[i % 4][15:0]}, 1);
        end
        report_and_stop;
    end
endmodule
